/* File: lem_pkg.sv */
// Constants for the loss-of-signal and event monitor register bank
//Contract
// - Error events of every kind are counted unless their type is masked.
// - Mask bit 4 set stops PLL clock errors counting; clear lets them count.
// - Mask bit 3 set stops FIFO errors counting; clear lets them count.
// - Mask bit 2 set stops clock detect errors counting; clear counts them.
// - Mask bit 1 set stops clock loss errors counting; clear counts them.
// - Mask bit 0 set stops data loss errors counting; clear counts them.
// - Override bit 1 forces the loss indicator low; clear leaves detection.
// - Override bit 0 forces the loss indicator high and wins over bit 1.
// - A status read returns a byte whose six low bits report each input.
// - Status bit 5 reads 1 with no forwarded clock and 0 with a clock.
// - Status bits 4 to 0 read 1 for a lane without data and 0 with data.
package lem_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_EVENT_COUNT_MASK = 8'h27;
	localparam logic [7:0] ADDR_LOSS_INDICATOR_OVERRIDE = 8'h28;
	localparam logic [7:0] ADDR_SIGNAL_LOSS_STATUS = 8'h29;

	// Field positions in the event count mask
	localparam int PLL_CLOCK_MASK_BIT = 4;
	localparam int FIFO_ERROR_MASK_BIT = 3;
	localparam int INPUT_CLOCK_DETECT_MASK_BIT = 2;
	localparam int CLOCK_LOSS_MASK_BIT = 1;
	localparam int DATA_LOSS_MASK_BIT = 0;

	// Field positions in the override register
	localparam int LOSS_FORCE_LOW_BIT = 1;
	localparam int LOSS_FORCE_HIGH_BIT = 0;

	// Field position of the clock flag in the status register
	localparam int CLOCK_LOSS_FLAG_BIT = 5;

	// Writable bits and reset values
	localparam logic [7:0] MASK_WRITABLE = 8'h1F;
	localparam logic [7:0] OVERRIDE_WRITABLE = 8'h03;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] OVERRIDE_RESET = 8'h00;
	localparam logic [7:0] READ_RESET = 8'h00;

	// Link shape
	localparam int NUM_LANES = 5;
	localparam int NUM_INPUTS = 6;

	// Inactivity time before an input counts as lost
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOSS_TIME_NS = 400;
	localparam int LOSS_CYCLES =
		(LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_W = 8;

	// Event counters saturate
	localparam int COUNT_W = 8;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_RESET = 8'h00;

endpackage

/* File: lem_activity_det.sv */
// Activity detector: flags one input lost after a quiet spell
module lem_activity_det #(
	parameter int unsigned TIMEOUT = lem_pkg::LOSS_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Monitored line, asynchronous
	input wire logic line_in,
	// Loss flag
	output logic loss_q
);

	localparam logic [7:0] LAST = 8'(TIMEOUT - 1);

	typedef struct packed {
		logic [2:0] sync;
		logic [7:0] idle;
		logic loss;
	} lem_det_t;

	lem_det_t st_q;
	lem_det_t st_d;
	logic toggled;

	// Edge seen only past the second stage, never on the first
	assign toggled = st_q.sync[2] ^ st_q.sync[1];

	always_comb begin
		st_d = st_q;
		st_d.sync = {st_q.sync[1:0], line_in};
		if (toggled) begin
			st_d.idle = '0;
			st_d.loss = 1'b0;
		end else if (st_q.idle >= LAST) begin
			st_d.loss = 1'b1;
		end else begin
			st_d.idle = st_q.idle + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign loss_q = st_q.loss;

endmodule

/* File: lem_monitor.sv */
// Loss-of-signal monitor, event masking and override register bank
module lem_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Link inputs, asynchronous
	input wire logic forwarded_input_clock,
	input wire logic [4:0] lane_data,
	// Error events from same-clock logic, one-cycle pulses
	input wire logic pll_clock_error,
	input wire logic fifo_error,
	input wire logic input_clock_detect_error,
	// Indicator and counts
	output logic signal_loss_indicator,
	output logic [7:0] pll_error_count,
	output logic [7:0] fifo_error_count,
	output logic [7:0] clock_detect_error_count,
	output logic [7:0] clock_loss_count,
	output logic [7:0] data_loss_count
);

	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] ovr;
		logic [7:0] rdata;
		logic indicator;
		logic clk_prev;
		logic [4:0] lane_prev;
		logic [7:0] cnt_pll;
		logic [7:0] cnt_fifo;
		logic [7:0] cnt_det;
		logic [7:0] cnt_clk;
		logic [7:0] cnt_data;
	} lem_regs_t;

	lem_regs_t st_q;
	lem_regs_t st_d;
	logic [5:0] loss_flags;
	logic [4:0] lane_data_loss_flags;
	logic clock_loss_flag;
	logic hit_pll;
	logic hit_fifo;
	logic hit_det;
	logic hit_clk;
	logic hit_data;

	// One detector per input; bit 5 is the forwarded clock
	for (genvar i = 0; i < lem_pkg::NUM_INPUTS; i++) begin : g_det
		lem_activity_det #(
			.TIMEOUT(lem_pkg::LOSS_CYCLES)
		) u_det (
			.ref_clk(ref_clk),
			.reset(reset),
			.line_in(i == lem_pkg::CLOCK_LOSS_FLAG_BIT ?
				forwarded_input_clock : lane_data[i % lem_pkg::NUM_LANES]),
			.loss_q(loss_flags[i])
		);
	end

	assign clock_loss_flag = loss_flags[lem_pkg::CLOCK_LOSS_FLAG_BIT];
	assign lane_data_loss_flags = loss_flags[4:0];

	// Masked events never reach the counters
	assign hit_pll = pll_clock_error
		& ~st_q.mask[lem_pkg::PLL_CLOCK_MASK_BIT];
	assign hit_fifo = fifo_error
		& ~st_q.mask[lem_pkg::FIFO_ERROR_MASK_BIT];
	assign hit_det = input_clock_detect_error
		& ~st_q.mask[lem_pkg::INPUT_CLOCK_DETECT_MASK_BIT];
	// Loss counts once per onset, not per cycle lost
	assign hit_clk = clock_loss_flag & ~st_q.clk_prev
		& ~st_q.mask[lem_pkg::CLOCK_LOSS_MASK_BIT];
	assign hit_data = |(lane_data_loss_flags & ~st_q.lane_prev)
		& ~st_q.mask[lem_pkg::DATA_LOSS_MASK_BIT];

	function automatic logic [7:0] sat_inc(input logic [7:0] c,
			input logic hit);
		if (hit && c != lem_pkg::COUNT_MAX) begin
			sat_inc = c + 8'h01;
		end else begin
			sat_inc = c;
		end
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.clk_prev = clock_loss_flag;
		st_d.lane_prev = lane_data_loss_flags;
		// Saturating so a stuck fault cannot wrap to a small count
		st_d.cnt_pll = sat_inc(st_q.cnt_pll, hit_pll);
		st_d.cnt_fifo = sat_inc(st_q.cnt_fifo, hit_fifo);
		st_d.cnt_det = sat_inc(st_q.cnt_det, hit_det);
		st_d.cnt_clk = sat_inc(st_q.cnt_clk, hit_clk);
		st_d.cnt_data = sat_inc(st_q.cnt_data, hit_data);
		if (reg_wr) begin
			if (reg_addr == lem_pkg::ADDR_EVENT_COUNT_MASK) begin
				st_d.mask = reg_wdata & lem_pkg::MASK_WRITABLE;
			end
			if (reg_addr == lem_pkg::ADDR_LOSS_INDICATOR_OVERRIDE) begin
				st_d.ovr = reg_wdata & lem_pkg::OVERRIDE_WRITABLE;
			end
		end
		if (reg_rd) begin
			unique case (reg_addr)
				lem_pkg::ADDR_EVENT_COUNT_MASK: begin
					st_d.rdata = st_q.mask;
				end
				lem_pkg::ADDR_LOSS_INDICATOR_OVERRIDE: begin
					st_d.rdata = st_q.ovr;
				end
				lem_pkg::ADDR_SIGNAL_LOSS_STATUS: begin
					st_d.rdata = {2'b00, loss_flags};
				end
				default: begin
					st_d.rdata = 8'h00;
				end
			endcase
		end
		// Force high beats force low
		if (st_q.ovr[lem_pkg::LOSS_FORCE_HIGH_BIT]) begin
			st_d.indicator = 1'b1;
		end else if (st_q.ovr[lem_pkg::LOSS_FORCE_LOW_BIT]) begin
			st_d.indicator = 1'b0;
		end else begin
			st_d.indicator = |loss_flags;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign signal_loss_indicator = st_q.indicator;
	assign pll_error_count = st_q.cnt_pll;
	assign fifo_error_count = st_q.cnt_fifo;
	assign clock_detect_error_count = st_q.cnt_det;
	assign clock_loss_count = st_q.cnt_clk;
	assign data_loss_count = st_q.cnt_data;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	AST_PLL_COUNTS: assert property (
		pll_clock_error && !st_q.mask[lem_pkg::PLL_CLOCK_MASK_BIT]
		&& st_q.cnt_pll != lem_pkg::COUNT_MAX
		|=> st_q.cnt_pll == $past(st_q.cnt_pll) + 8'h01)
		else $error("Unmasked PLL error not counted");

	AST_PLL_MASKED: assert property (
		st_q.mask[lem_pkg::PLL_CLOCK_MASK_BIT] [*2] |-> $stable(st_q.cnt_pll))
		else $error("Masked PLL error counted");

	AST_FIFO_MASK: assert property (
		fifo_error && st_q.cnt_fifo != lem_pkg::COUNT_MAX
		|=> st_q.cnt_fifo == $past(st_q.cnt_fifo)
			+ {7'h00, !$past(st_q.mask[lem_pkg::FIFO_ERROR_MASK_BIT])})
		else $error("FIFO error count disagrees with mask");

	AST_DET_MASK: assert property (
		input_clock_detect_error && st_q.cnt_det != lem_pkg::COUNT_MAX
		|=> st_q.cnt_det == $past(st_q.cnt_det)
			+ {7'h00, !$past(st_q.mask[lem_pkg::INPUT_CLOCK_DETECT_MASK_BIT])})
		else $error("Clock detect count disagrees with mask");

	AST_CLK_LOSS_ONSET: assert property (
		$rose(clock_loss_flag) && !st_q.mask[lem_pkg::CLOCK_LOSS_MASK_BIT]
		&& st_q.cnt_clk != lem_pkg::COUNT_MAX
		|=> st_q.cnt_clk == $past(st_q.cnt_clk) + 8'h01)
		else $error("Clock loss onset not counted");

	AST_CLK_LOSS_MASKED: assert property (
		st_q.mask[lem_pkg::CLOCK_LOSS_MASK_BIT]
		|=> st_q.cnt_clk == $past(st_q.cnt_clk))
		else $error("Masked clock loss counted");

	AST_DATA_LOSS_ONSET: assert property (
		|(lane_data_loss_flags & ~$past(lane_data_loss_flags))
		&& !st_q.mask[lem_pkg::DATA_LOSS_MASK_BIT]
		&& st_q.cnt_data != lem_pkg::COUNT_MAX
		|=> st_q.cnt_data == $past(st_q.cnt_data) + 8'h01)
		else $error("Data loss onset not counted");

	AST_DATA_LOSS_MASKED: assert property (
		st_q.mask[lem_pkg::DATA_LOSS_MASK_BIT]
		|=> st_q.cnt_data == $past(st_q.cnt_data))
		else $error("Masked data loss counted");

	AST_NORMAL_LOSS: assert property (
		!st_q.ovr[lem_pkg::LOSS_FORCE_HIGH_BIT]
		&& !st_q.ovr[lem_pkg::LOSS_FORCE_LOW_BIT]
		|=> signal_loss_indicator == |$past(loss_flags))
		else $error("Indicator does not follow detection");

	AST_FORCE_LOW: assert property (
		st_q.ovr[lem_pkg::LOSS_FORCE_LOW_BIT]
		&& !st_q.ovr[lem_pkg::LOSS_FORCE_HIGH_BIT]
		|=> !signal_loss_indicator)
		else $error("Force low not obeyed");

	AST_FORCE_HIGH: assert property (
		st_q.ovr[lem_pkg::LOSS_FORCE_HIGH_BIT] |=> signal_loss_indicator)
		else $error("Force high not obeyed or lost priority");

	AST_STATUS_READ: assert property (
		reg_rd && reg_addr == lem_pkg::ADDR_SIGNAL_LOSS_STATUS
		|=> reg_rdata == {2'b00, $past(loss_flags)})
		else $error("Status read does not match flags");

	AST_MASK_WRITE: assert property (
		reg_wr && reg_addr == lem_pkg::ADDR_EVENT_COUNT_MASK
		|=> st_q.mask == ($past(reg_wdata) & lem_pkg::MASK_WRITABLE))
		else $error("Mask write kept reserved bits");

	AST_RESERVED_ZERO: assert property (
		reg_rd && (reg_addr == lem_pkg::ADDR_EVENT_COUNT_MASK
			|| reg_addr == lem_pkg::ADDR_LOSS_INDICATOR_OVERRIDE)
		|=> reg_rdata[7:5] == 3'b000 && (reg_rdata[7:2] == 6'h00
			|| $past(reg_addr) == lem_pkg::ADDR_EVENT_COUNT_MASK))
		else $error("Reserved bits read nonzero");

endmodule

/* File: lem_link_model.sv */
// Host side model driving the forwarded clock and five data lanes
module lem_link_model (
	// Per line run enables, bit 5 clock, bits 4:0 lanes
	input wire logic [5:0] run,
	// Link outputs
	output logic forwarded_input_clock,
	output logic [4:0] lane_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		forwarded_input_clock = 1'b0;
		lane_data = 5'h00;
	end
	// Stopped lines hold level; a stuck line is what a lost input looks like
	always #40 begin
		if (run[5]) begin
			forwarded_input_clock = ~forwarded_input_clock;
		end
		lane_data = lane_data ^ run[4:0];
	end
endmodule

/* File: lem_monitor_bench.sv */
// Self-checking bench for the loss monitor register bank
module lem_monitor_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [5:0] run = 6'h3F;
	logic [2:0] ev = 3'h0;
	logic [7:0] reg_rdata;
	logic fclk;
	logic [4:0] lanes;
	logic ind;
	logic [7:0] c_pll, c_fifo, c_det, c_clk, c_dat;
	int error_cnt = 0;
	int checks_done = 0;
	always #5 ref_clk = ~ref_clk;
	lem_link_model link (.run(run), .forwarded_input_clock(fclk),
		.lane_data(lanes));
	lem_monitor dut (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.forwarded_input_clock(fclk), .lane_data(lanes),
		.pll_clock_error(ev[2]), .fifo_error(ev[1]),
		.input_clock_detect_error(ev[0]), .signal_loss_indicator(ind),
		.pll_error_count(c_pll), .fifo_error_count(c_fifo),
		.clock_detect_error_count(c_det), .clock_loss_count(c_clk),
		.data_loss_count(c_dat));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask
	// Read data is registered, so it is looked at one cycle on
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic pulse;
		@(negedge ref_clk);
		ev = 3'h7;
		@(negedge ref_clk);
		ev = 3'h0;
		idle(2);
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		rd(8'h27, 8'h00);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		wr(8'h27, 8'hFF);
		rd(8'h27, 8'h1F);
		wr(8'h28, 8'hFF);
		rd(8'h28, 8'h03);
		chk({7'h00, ind}, 8'h01);
		wr(8'h29, 8'hFF);
		rd(8'h29, 8'h00);
		rd(8'h2A, 8'h00);
		pulse();
		chk(c_pll, 8'h00);
		chk(c_fifo, 8'h00);
		chk(c_det, 8'h00);
		wr(8'h27, 8'h00);
		wr(8'h28, 8'h00);
		pulse();
		chk(c_pll, 8'h01);
		chk(c_fifo, 8'h01);
		chk(c_det, 8'h01);
		run = 6'h00;
		idle(60);
		rd(8'h29, 8'h3F);
		chk({7'h00, ind}, 8'h01);
		chk(c_clk, 8'h01);
		chk(c_dat, 8'h01);
		wr(8'h28, 8'h02);
		idle(2);
		chk({7'h00, ind}, 8'h00);
		wr(8'h28, 8'h03);
		idle(2);
		chk({7'h00, ind}, 8'h01);
		wr(8'h28, 8'h00);
		run = 6'h3F;
		idle(20);
		rd(8'h29, 8'h00);
		chk({7'h00, ind}, 8'h00);
		run = 6'h3B;
		idle(60);
		rd(8'h29, 8'h04);
		chk(c_dat, 8'h02);
		run = 6'h3F;
		idle(20);
		wr(8'h27, 8'h03);
		run = 6'h00;
		idle(60);
		rd(8'h29, 8'h3F);
		chk(c_clk, 8'h01);
		chk(c_dat, 8'h02);
		end_sim();
	end
endmodule
